// [logic/sgx_pkg.sv]
// Purpose: shared constants and types of the serial gpio shift controller
// Assumes: 25 MHz system clock, classic wishbone register bus, 32-bit data
// Notes: offsets are byte addresses; each register is one aligned word
package sgx_pkg;
  // geometry of the serial chain
  localparam int CLK_PERIOD_NS = 40;
  localparam int NUM_PORTS = 32;
  localparam int BITS_MAX = 4;
  localparam int SD_COUNT = 16;
  localparam int MAX_BURST_BITS = NUM_PORTS * BITS_MAX;

  // register byte offsets and address pages
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_CLOCK = 8'h04;
  localparam logic [7:0] ADR_PORT_ENA = 8'h08;
  localparam logic [7:0] ADR_LOS = 8'h0c;
  localparam logic [3:0] PAGE_OUT = 4'h1;
  localparam logic [3:0] PAGE_IN = 4'h2;
  localparam logic [1:0] PAGE_SD_MAP = 2'h1;

  // configuration word fields
  localparam int CFG_ONE_SHOT = 0;
  localparam int CFG_REPEAT = 1;
  localparam int CFG_GAP_DIS = 2;
  localparam int CFG_WIDTH_LSB = 3;
  localparam int CFG_LD_POL = 5;
  localparam int CFG_REV_IN = 6;
  localparam int CFG_REV_OUT = 7;
  localparam int CFG_GAP_LSB = 8;
  localparam int CFG_BUSY = 31;
  localparam int SD_MAP_ENA = 8;

  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [7:0] CLOCK_RATE_RST = 8'h03;
  localparam logic [31:0] PORT_ENA_RST = 32'h0000_0000;

  // timing
  localparam int LOAD_MIN_NS = 25;
  localparam int LOAD_MAX_NS = 30;
  localparam int LOAD_CYC_RAW = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CYCLES = (LOAD_CYC_RAW < 1) ? 1 : LOAD_CYC_RAW;
  localparam int GAP_STEP_NS = 1000000;
  localparam int GAP_STEP_CYCLES = GAP_STEP_NS / CLK_PERIOD_NS;
  localparam logic [5:0] GAP_MAX_STEPS = 6'h21;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LOAD, ST_GAP} sgx_state_e;
endpackage

// [logic/sgx_shift_if.sv]
// Purpose: carrier between the shift engine and the shift clock divider
// Assumes: both ends sit on i_clk_sys
// Notes: ticks are one-cycle pulses at the clock toggle
`timescale 1ns/1ps
interface sgx_shift_if;
  logic run;
  logic [7:0] half;
  logic sclk;
  logic tick_rise;
  logic tick_fall;
  modport gen (input run, input half, output sclk, output tick_rise, output tick_fall);
  modport eng (output run, output half, input sclk, input tick_rise, input tick_fall);
endinterface

// [logic/sgx_shift_clk.sv]
// Purpose: shift clock divider, half period of half+1 system cycles
// Assumes: run is held for the whole burst
// Notes: clock idles low, so every burst starts from a clean low phase
`timescale 1ns/1ps
module sgx_shift_clk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // engine side
  sgx_shift_if.gen sh
);
  logic [7:0] cnt;
  logic wrap;

  // toggle point of the divided clock
  assign wrap = sh.run && (cnt == sh.half);
  assign sh.tick_rise = wrap && !sh.sclk;
  assign sh.tick_fall = wrap && sh.sclk;

  // half period counter
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sh.run || wrap) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // divided clock, forced low outside bursts
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sh.run) begin
      sh.sclk <= 1'b0;
    end else if (wrap) begin
      sh.sclk <= ~sh.sclk;
    end
  end
endmodule

// [logic/sgx_serial_gpio_shift_controller.sv]
// Purpose: serial gpio expander with wishbone registers and signal detect merge
// Assumes: 25 MHz clock; shift_clock_rate of 2 or more for input sampling
// Notes: data out changes on falling shift edges, input sampled at rising ones
`timescale 1ns/1ps
module sgx_serial_gpio_shift_controller #(
  parameter int GAP_STEP_CYCLES = sgx_pkg::GAP_STEP_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // serial chain pins
  output logic o_serial_shift_clock_out,
  output logic o_serial_data_out,
  input wire logic i_serial_data_in,
  output logic o_serial_load_strobe,
  // parallel signal detect pins and port module loss-of-signal
  input wire logic [sgx_pkg::SD_COUNT-1:0] i_parallel_signal_detect_in,
  output logic [sgx_pkg::NUM_PORTS-1:0] o_loss_of_signal
);
  import sgx_pkg::*;

  // software registers
  logic one_burst_request;
  logic repeat_bursts;
  logic burst_gap_disable;
  logic [1:0] bits_per_port;
  logic load_strobe_polarity;
  logic input_order_reverse;
  logic output_order_reverse;
  logic [5:0] burst_gap_length;
  logic [7:0] shift_clock_rate;
  logic [31:0] expander_port_enable;
  logic [31:0] out_word [BITS_MAX];
  logic [31:0] sampled_input_bits [BITS_MAX];
  logic [4:0] signal_detect_port_index [SD_COUNT];
  logic [SD_COUNT-1:0] sd_ena;

  // engine state
  sgx_state_e state, next_state;
  logic [4:0] out_port, next_out_port;
  logic [4:0] in_port, next_in_port;
  logic [1:0] bit_idx, next_bit;
  logic [3:0] load_cnt;
  logic [23:0] gap_cnt;
  logic [5:0] nxt_out, nxt_in, first_out, first_in;
  logic [5:0] gap_steps;
  logic [23:0] gap_total;
  logic burst_done;

  // synchronised pins
  logic din_s;
  logic [SD_COUNT-1:0] sd_s;

  // wishbone
  logic wb_req, wb_wr;
  logic [31:0] cfg_word, cfg_new, next_rdata;
  logic [SD_COUNT-1:0] sd_pick;
  logic [NUM_PORTS-1:0] next_los;

  sgx_shift_if sh ();

  sgx_shift_clk u_clk (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .sh(sh.gen)
  );

  // data input and detect pins come from outside, two flops each
  sgx_sync2 #(.W(SD_COUNT + 1)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d({i_parallel_signal_detect_in, i_serial_data_in}),
    .o_q({sd_s, din_s})
  );

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // nearest enabled port in the shift direction, {found, index}
  function automatic logic [5:0] next_port(input logic [4:0] cur, input logic first,
                                           input logic rev, input logic [31:0] ena);
    logic [5:0] r;
    logic [5:0] p;
    r = 6'h00;
    // far to near so that the nearest enabled port wins
    for (int d = 32; d >= 1; d--) begin
      if (first) p = rev ? 6'(32 - d) : 6'(d - 1);
      else p = rev ? ({1'b0, cur} - 6'(d)) : ({1'b0, cur} + 6'(d));
      if (p < 6'h20 && ena[p[4:0]]) r = {1'b1, p[4:0]};
    end
    return r;
  endfunction

  // wishbone handshake, one wait state per access
  assign wb_req = i_wb_cyc && i_wb_stb;
  assign wb_wr = wb_req && o_wb_ack && i_wb_we;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req && !o_wb_ack;
    end
  end

  // packed view of the configuration word
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[CFG_ONE_SHOT] = one_burst_request;
    cfg_word[CFG_REPEAT] = repeat_bursts;
    cfg_word[CFG_GAP_DIS] = burst_gap_disable;
    cfg_word[CFG_WIDTH_LSB +: 2] = bits_per_port;
    cfg_word[CFG_LD_POL] = load_strobe_polarity;
    cfg_word[CFG_REV_IN] = input_order_reverse;
    cfg_word[CFG_REV_OUT] = output_order_reverse;
    cfg_word[CFG_GAP_LSB +: 6] = burst_gap_length;
    cfg_word[CFG_BUSY] = (state != ST_IDLE);
    cfg_new = merge(cfg_word, i_wb_dat, i_wb_sel);
  end

  // read mux; unmapped words answer zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_wb_adr[7:6] == PAGE_SD_MAP) begin
      next_rdata[4:0] = signal_detect_port_index[i_wb_adr[5:2]];
      next_rdata[SD_MAP_ENA] = sd_ena[i_wb_adr[5:2]];
    end else if (i_wb_adr[7:4] == PAGE_OUT) begin
      next_rdata = out_word[i_wb_adr[3:2]];
    end else if (i_wb_adr[7:4] == PAGE_IN) begin
      next_rdata = sampled_input_bits[i_wb_adr[3:2]];
    end else if ({i_wb_adr[7:2], 2'b00} == ADR_CFG) begin
      next_rdata = cfg_word;
    end else if ({i_wb_adr[7:2], 2'b00} == ADR_CLOCK) begin
      next_rdata[7:0] = shift_clock_rate;
    end else if ({i_wb_adr[7:2], 2'b00} == ADR_PORT_ENA) begin
      next_rdata = expander_port_enable;
    end else if ({i_wb_adr[7:2], 2'b00} == ADR_LOS) begin
      next_rdata = o_loss_of_signal;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (wb_req && !o_wb_ack) begin
      o_wb_dat <= next_rdata;
    end
  end

  // configuration word; a single shot set in the finishing cycle survives
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      one_burst_request <= CFG_RST[CFG_ONE_SHOT];
      repeat_bursts <= CFG_RST[CFG_REPEAT];
      burst_gap_disable <= CFG_RST[CFG_GAP_DIS];
      bits_per_port <= CFG_RST[CFG_WIDTH_LSB +: 2];
      load_strobe_polarity <= CFG_RST[CFG_LD_POL];
      input_order_reverse <= CFG_RST[CFG_REV_IN];
      output_order_reverse <= CFG_RST[CFG_REV_OUT];
      burst_gap_length <= CFG_RST[CFG_GAP_LSB +: 6];
    end else if (wb_wr && {i_wb_adr[7:2], 2'b00} == ADR_CFG) begin
      one_burst_request <= cfg_new[CFG_ONE_SHOT] || (one_burst_request && !burst_done
                           && !i_wb_sel[0]);
      repeat_bursts <= cfg_new[CFG_REPEAT];
      burst_gap_disable <= cfg_new[CFG_GAP_DIS];
      bits_per_port <= cfg_new[CFG_WIDTH_LSB +: 2];
      load_strobe_polarity <= cfg_new[CFG_LD_POL];
      input_order_reverse <= cfg_new[CFG_REV_IN];
      output_order_reverse <= cfg_new[CFG_REV_OUT];
      burst_gap_length <= cfg_new[CFG_GAP_LSB +: 6];
    end else if (burst_done) begin
      one_burst_request <= 1'b0;
    end
  end

  // clock rate, port enables, output bit sources and detect maps
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      shift_clock_rate <= CLOCK_RATE_RST;
      expander_port_enable <= PORT_ENA_RST;
      out_word <= '{default: 32'h0000_0000};
      signal_detect_port_index <= '{default: 5'h00};
      sd_ena <= '0;
    end else if (wb_wr) begin
      if (i_wb_adr[7:6] == PAGE_SD_MAP) begin
        if (i_wb_sel[0]) signal_detect_port_index[i_wb_adr[5:2]] <= i_wb_dat[4:0];
        if (i_wb_sel[1]) sd_ena[i_wb_adr[5:2]] <= i_wb_dat[SD_MAP_ENA];
      end else if (i_wb_adr[7:4] == PAGE_OUT) begin
        out_word[i_wb_adr[3:2]] <= merge(out_word[i_wb_adr[3:2]], i_wb_dat, i_wb_sel);
      end else if ({i_wb_adr[7:2], 2'b00} == ADR_CLOCK) begin
        if (i_wb_sel[0]) shift_clock_rate <= i_wb_dat[7:0];
      end else if ({i_wb_adr[7:2], 2'b00} == ADR_PORT_ENA) begin
        expander_port_enable <= merge(expander_port_enable, i_wb_dat, i_wb_sel);
      end
    end
  end

  // port walking, the same enables and width for both streams
  assign first_out = next_port(5'h00, 1'b1, output_order_reverse, expander_port_enable);
  assign first_in = next_port(5'h00, 1'b1, input_order_reverse, expander_port_enable);
  assign nxt_out = next_port(out_port, 1'b0, output_order_reverse, expander_port_enable);
  assign nxt_in = next_port(in_port, 1'b0, input_order_reverse, expander_port_enable);
  assign gap_steps = (burst_gap_length > GAP_MAX_STEPS) ? GAP_MAX_STEPS : burst_gap_length;
  assign gap_total = 24'(gap_steps * GAP_STEP_CYCLES);
  assign burst_done = (state == ST_LOAD) && (load_cnt == 4'h1);
  assign sh.run = (state == ST_SHIFT);
  assign sh.half = shift_clock_rate;

  // burst sequencer
  always_comb begin
    next_state = state;
    next_out_port = out_port;
    next_in_port = in_port;
    next_bit = bit_idx;
    unique case (state)
      ST_IDLE: begin
        if (one_burst_request || repeat_bursts) begin
          next_bit = 2'h0;
          if (first_out[5]) begin
            next_state = ST_SHIFT;
            next_out_port = first_out[4:0];
            next_in_port = first_in[4:0];
          end else begin
            next_state = ST_LOAD;
          end
        end
      end
      ST_SHIFT: begin
        if (sh.tick_fall) begin
          if (bit_idx == bits_per_port) begin
            next_bit = 2'h0;
            if (nxt_out[5]) begin
              next_out_port = nxt_out[4:0];
              next_in_port = nxt_in[4:0];
            end else begin
              next_state = ST_LOAD;
            end
          end else begin
            next_bit = bit_idx + 2'h1;
          end
        end
      end
      ST_LOAD: begin
        if (load_cnt == 4'h1) begin
          // gap only between repeated bursts, and only when not disabled
          if (repeat_bursts && !burst_gap_disable && gap_steps != 6'h00) begin
            next_state = ST_GAP;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (gap_cnt == 24'h0) next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= ST_IDLE;
      out_port <= 5'h00;
      in_port <= 5'h00;
      bit_idx <= 2'h0;
    end else begin
      state <= next_state;
      out_port <= next_out_port;
      in_port <= next_in_port;
      bit_idx <= next_bit;
    end
  end

  // load pulse length and gap counters
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      load_cnt <= 4'h0;
      gap_cnt <= 24'h0;
    end else begin
      if (next_state == ST_LOAD && state != ST_LOAD) load_cnt <= 4'(LOAD_CYCLES);
      else if (load_cnt != 4'h0) load_cnt <= load_cnt - 4'h1;
      if (next_state == ST_GAP && state != ST_GAP) gap_cnt <= gap_total - 24'h1;
      else if (gap_cnt != 24'h0) gap_cnt <= gap_cnt - 24'h1;
    end
  end

  // data out moves only at burst start and at falling shift edges, chain captures on rising
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_serial_data_out <= 1'b0;
    end else if (next_state == ST_SHIFT) begin
      o_serial_data_out <= out_word[next_bit][next_out_port];
    end else begin
      o_serial_data_out <= 1'b0;
    end
  end

  // input sampled at the rising edge, before the chain shifts on it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sampled_input_bits <= '{default: 32'h0000_0000};
    end else if (state == ST_SHIFT && sh.tick_rise) begin
      sampled_input_bits[bit_idx][in_port] <= din_s;
    end
  end

  // load strobe, polarity applied at the pin
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_serial_load_strobe <= 1'b0;
    end else begin
      o_serial_load_strobe <= (next_state == ST_LOAD) ^ load_strobe_polarity;
    end
  end

  assign o_serial_shift_clock_out = sh.sclk;

  // bit zero per port, parallel detects override, higher index wins
  always_comb begin
    next_los = sampled_input_bits[0];
    sd_pick = '0;
    for (int n = 0; n < SD_COUNT; n++) begin
      if (sd_ena[n]) begin
        next_los[signal_detect_port_index[n]] = sd_s[n];
        if (signal_detect_port_index[n] == 5'h00) sd_pick[n] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_loss_of_signal <= '0;
    end else begin
      o_loss_of_signal <= next_los;
    end
  end

  // checks
  logic [7:0] burst_bits;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state == ST_IDLE) burst_bits <= 8'h00;
    else if (state == ST_SHIFT && sh.tick_fall) burst_bits <= burst_bits + 8'h01;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_load_one_pulse: assert property ($rose(state == ST_LOAD) |=> state != ST_LOAD)
    else $error("load strobe longer than one cycle");
  chk_load_after_burst: assert property (
    (state == ST_SHIFT && next_state != ST_SHIFT) |=> state == ST_LOAD)
    else $error("burst end not followed by load");
  chk_ld_polarity: assert property (
    o_serial_load_strobe == ((state == ST_LOAD) ^ $past(load_strobe_polarity)))
    else $error("load strobe level wrong");
  chk_ports_enabled: assert property (state == ST_SHIFT |->
    expander_port_enable[out_port] && expander_port_enable[in_port])
    else $error("disabled port in stream");
  chk_burst_bound: assert property (burst_bits <= 8'(MAX_BURST_BITS))
    else $error("burst too long");
  chk_width_bound: assert property (state == ST_SHIFT |-> bit_idx <= bits_per_port)
    else $error("bit index beyond width");
  chk_oneshot_clear: assert property (
    (burst_done && !(wb_wr && i_wb_adr[7:2] == 6'h00)) |=> !one_burst_request)
    else $error("single shot not cleared");
  chk_do_stable: assert property ((state == ST_SHIFT && !sh.tick_fall) |=>
    $stable(o_serial_data_out) || state != ST_SHIFT)
    else $error("data out moved off falling edge");
  chk_gap_entry: assert property ($rose(state == ST_GAP) |-> gap_cnt == gap_total - 24'h1)
    else $error("gap length wrong");
  chk_los_default: assert property (sd_pick == '0 |=>
    o_loss_of_signal[0] == $past(sampled_input_bits[0][0]))
    else $error("bit zero not forwarded");

  cov_burst_rev: cover property (burst_done && output_order_reverse && !input_order_reverse);
  cov_repeat_gap: cover property (state == ST_GAP ##1 state == ST_IDLE);
  cov_override: cover property (sd_ena != '0 && sd_s != '0);
endmodule

// [logic/sgx_sync2.sv]
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: bits are independent levels
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ps
module sgx_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

// [testbench/sgx_chain_model.sv]
// Purpose: behavioural board chain of shift registers behind the expander
// Assumes: capture on the rising shift clock, load on the active strobe edge
// Notes: one strobe latches outputs and samples the parallel inputs
`timescale 1ns/1ps
module sgx_chain_model (
  // chain pins
  input wire logic i_sclk,
  input wire logic i_sdo,
  input wire logic i_ld_act,
  output logic o_sdi,
  // board side
  input wire logic [127:0] i_par_in,
  output logic [127:0] o_par_out,
  output int o_loads,
  output int o_bits
);
  logic [127:0] out_sh = '0;
  logic [127:0] in_sh = '0;
  int cnt = 0;
  initial begin
    o_par_out = '0;
    o_loads = 0;
    o_bits = 0;
  end
  // both chains move on the rising shift clock, zeros fill the tail
  // out_sh alone is what a load-less output chain shows, toggling while shifting
  always @(posedge i_sclk) begin
    out_sh <= {out_sh[126:0], i_sdo};
    in_sh <= {in_sh[126:0], 1'b0};
    cnt <= cnt + 1;
  end
  // strobe applies shifted outputs and captures fresh inputs
  always @(posedge i_ld_act) begin
    o_par_out <= out_sh;
    in_sh <= i_par_in;
    o_bits <= cnt;
    cnt <= 0;
    o_loads <= o_loads + 1;
  end
  assign o_sdi = in_sh[127];
endmodule

// [testbench/serial_gpio_shift_controller_tb.sv]
// Purpose: register level bench of the serial gpio shift controller
// Assumes: gap step shortened to 20 cycles
// Notes: stream and input expectations are rebuilt from port enables and width
`timescale 1ns/1ps
module serial_gpio_shift_controller_tb;
  import sgx_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pol = 0, sclk_q = 0, act_q = 0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, q, rdat, los, c;
  logic [3:0] sel = '0;
  logic [15:0] pd = '0;
  logic [127:0] par = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, pout, ex, msk;
  logic [31:0] ob [4] = '{32'hdead_beef, 32'h1357_9bdf, 32'h0f0f_3c3c, 32'ha5a5_0ff0};
  logic [31:0] ei [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] ena_t [6] = '{32'h5, 32'h5, 32'h5, 32'hffff_ffff, 32'hffff_ffff, 32'h8000_0001};
  int w_t [6] = '{2, 2, 2, 1, 4, 3};
  logic [1:0] rv_t [6] = '{2'b00, 2'b10, 2'b01, 2'b00, 2'b11, 2'b00};
  logic [7:0] rt_t [6] = '{8'h03, 8'h03, 8'h02, 8'h05, 8'h03, 8'h04};
  logic ack, sclk, sdo, sdi, ld, ld_act;
  int bad_count = 0, tests_run = 0, loads, nbits, cc = 0, run = 0, lrun = 0;
  int lst = 0, intv = 0, sr = 0, sper = 0, l0, n, m, po, pi;
  assign ld_act = ld ^ pol;
  always #20 clk = ~clk;
  sgx_serial_gpio_shift_controller #(.GAP_STEP_CYCLES(20)) u_sgx_serial_gpio_shift_controller (
    .i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_serial_shift_clock_out(sclk), .o_serial_data_out(sdo), .i_serial_data_in(sdi),
    .o_serial_load_strobe(ld), .i_parallel_signal_detect_in(pd), .o_loss_of_signal(los));
  sgx_chain_model u_sgx_chain_model (.i_sclk(sclk), .i_sdo(sdo), .i_ld_act(ld_act),
    .o_sdi(sdi), .i_par_in(par), .o_par_out(pout), .o_loads(loads), .o_bits(nbits));
  // strobe width and spacing, shift clock period, measured in system cycles
  always @(posedge clk) begin
    cc <= cc + 1;
    sclk_q <= sclk;
    act_q <= ld_act;
    if (ld_act) run <= run + 1;
    else if (act_q) begin
      lrun <= run;
      run <= 0;
    end
    if (ld_act && !act_q) begin
      intv <= cc - lst;
      lst <= cc;
    end
    if (sclk && !sclk_q) begin
      sper <= cc - sr;
      sr <= cc;
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    if (k >= 40) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // single shot, then poll until the request bit and busy have cleared
  task automatic burst(input logic [31:0] cf);
    int k;
    k = 0;
    xfer(1, ADR_CFG, cf | 32'h1);
    do begin
      xfer(0, ADR_CFG, 0);
      k++;
    end while ((q[CFG_ONE_SHOT] !== 1'b0 || q[CFG_BUSY] !== 1'b0) && k < 1000);
    if (k >= 1000) begin
      bad_count++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    xfer(0, ADR_CFG, 0);
    chk("cfg reset", CFG_RST, q);
    xfer(0, ADR_CLOCK, 0);
    chk("clock reset", {24'h0, CLOCK_RATE_RST}, q);
    xfer(0, ADR_PORT_ENA, 0);
    chk("enable reset", PORT_ENA_RST, q);
    xfer(1, 8'hfc, 32'hffff_ffff);
    xfer(0, 8'hfc, 0);
    chk("unmapped", 32'h0, q);
    xfer(1, ADR_CFG, 32'h8000_3f00);
    xfer(0, ADR_CFG, 0);
    chk("gap field busy ro", {18'h0, 6'h3f, 8'h0}, q);
    for (int b = 0; b < 4; b++) xfer(1, {PAGE_OUT, 2'(b), 2'b00}, ob[b]);
    // table of enables, widths, order reversal and shift rates
    for (int i = 0; i < 6; i++) begin
      xfer(1, ADR_CLOCK, {24'h0, rt_t[i]});
      xfer(1, ADR_PORT_ENA, ena_t[i]);
      l0 = loads;
      c = (32'(rv_t[i]) << CFG_REV_IN) | (32'(w_t[i] - 1) << CFG_WIDTH_LSB);
      burst(c);
      ex = '0;
      n = 0;
      m = 0;
      for (int k = 0; k < 32; k++) begin
        po = rv_t[i][1] ? 31 - k : k;
        pi = rv_t[i][0] ? 31 - k : k;
        for (int b = 0; b < w_t[i]; b++) begin
          if (ena_t[i][po]) begin
            ex = {ex[126:0], ob[b][po]};
            n++;
          end
          if (ena_t[i][pi]) begin
            ei[b][pi] = (i == 0) ? 1'b0 : par[127 - m];
            m++;
          end
        end
      end
      msk = (n == 128) ? '1 : ((128'h1 << n) - 1);
      chk("bit count", n, nbits);
      chk("load count", l0 + 1, loads);
      chk("load width", LOAD_CYCLES, lrun);
      chk("shift period", 2 * (rt_t[i] + 1), sper);
      for (int b = 0; b < 4; b++) begin
        chk("chain out", 32'((ex & msk) >> (32 * b)), 32'((pout & msk) >> (32 * b)));
        xfer(0, {PAGE_IN, 2'(b), 2'b00}, 0);
        chk("input bits", ei[b], q);
      end
      xfer(0, ADR_LOS, 0);
      chk("los reg", ei[0], q);
      chk("los pin", ei[0], los);
    end
    // free running bursts with a two-step gap of 40 cycles, then without gap, then stopped
    xfer(1, ADR_PORT_ENA, 32'h1);
    xfer(1, ADR_CFG, 32'h0000_0202);
    repeat (300) @(posedge clk);
    chk("gap spacing", 1, 32'(intv >= 40 && intv <= 60));
    xfer(1, ADR_CFG, 32'h0000_0206);
    repeat (100) @(posedge clk);
    chk("no gap spacing", 1, 32'(intv >= 9 && intv < 20));
    xfer(1, ADR_CFG, 32'h0);
    repeat (40) @(posedge clk);
    l0 = loads;
    repeat (200) @(posedge clk);
    chk("repeat stopped", l0, loads);
    // detect 3 mapped onto port 1 overrides its sampled input bit
    xfer(1, {PAGE_SD_MAP, 4'h3, 2'b00}, 32'h0000_0101);
    pd <= 16'h0008;
    repeat (6) @(posedge clk);
    chk("detect high", ei[0] | 32'h2, los);
    pd <= 16'h0000;
    repeat (6) @(posedge clk);
    chk("detect low", ei[0] & ~32'h2, los);
    // inverted strobe: idles high, one low cycle per burst
    xfer(1, ADR_CFG, 32'h20);
    pol <= 1;
    repeat (4) @(posedge clk);
    chk("strobe idle", 1, 32'(ld));
    l0 = loads;
    burst(32'h20);
    chk("inverted load", l0 + 1, loads);
    chk("inverted width", LOAD_CYCLES, lrun);
    print_verdict();
  end
endmodule
